// ### hw/ifep_top.sv
// interrupt flag, enable mask and vector rank bookkeeping
// assumes apb master on core_clk_i, requests synchronous to it
`timescale 1ns/1ps
`default_nettype none
`include "ifep_defines.svh"
module ifep_top #(
    parameter int NSRC = 32,
    parameter int RANK_WORDS = `IFEP_RANK_WORDS
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // request lines from peripherals
    input wire logic [NSRC-1:0] irq_req_i,
    // vector to processor core
    output logic vec_valid_o,
    output logic [4:0] vec_num_o,
    output logic [2:0] vec_level_o,
    output logic [1:0] vec_sublevel_o,
    // proximity timer reload
    output logic prox_load_o,
    output logic [31:0] prox_value_o,
    // interrupt line
    output logic irq_o
);
    localparam int IW = $clog2(RANK_WORDS);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ifep_pkg::ifep_apb_state_t st_q, st_d;
    logic [31:0] reload_q, reload_d;
    logic [31:0] flag_q, flag_d;
    logic [31:0] mask_q, mask_d;
    logic [1:0] stat_q, stat_d;
    logic [1:0] imask_q, imask_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    logic vv_d, vv_q;
    logic [4:0] vn_d, vn_q;
    ifep_pkg::ifep_level_t vl_d, vl_q;
    ifep_pkg::ifep_sublevel_t vs_d, vs_q;
    logic pl_d, pl_q;
    logic irq_d, irq_q;

    logic [RANK_WORDS*32-1:0] rank_all;
    logic [31:0] rank_rd;
    logic rank_we;
    logic [IW-1:0] rank_idx;
    logic is_rank, rd_rank_q, rd_rank_d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic ifep_pkg::ifep_level_t lvl_of(
        input logic [RANK_WORDS*32-1:0] all, input int s);
        logic [31:0] w;
        w = all[(s/4)*32 +: 32];
        return w[(s%4)*`IFEP_SLOT_STRIDE+`IFEP_LVL_LSB +: 3];
    endfunction

    function automatic ifep_pkg::ifep_sublevel_t sub_of(
        input logic [RANK_WORDS*32-1:0] all, input int s);
        logic [31:0] w;
        w = all[(s/4)*32 +: 32];
        return w[(s%4)*`IFEP_SLOT_STRIDE +: 2];
    endfunction

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        return a == o;
    endfunction

    assign is_rank = paddr_i >= `IFEP_OFS_RANK0 &&
        paddr_i < 12'(`IFEP_OFS_RANK0 + RANK_WORDS * 4) &&
        paddr_i[1:0] == 2'b00;
    assign rank_idx = IW'((paddr_i - `IFEP_OFS_RANK0) >> 2);
    assign rank_we = st_q == ifep_pkg::IFEP_APB_ACCESS && psel_i &&
        penable_i && pwrite_i && is_rank;

    ifep_rank_mem #(.WORDS(RANK_WORDS)) u_rank (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(rank_we),
        .wr_idx_i(rank_idx),
        .wr_data_i(pwdata_i & `IFEP_RANK_IMPL),
        .rd_idx_i(rank_idx),
        .rd_data_o(rank_rd),
        .all_o(rank_all)
    );

    // ------------------------------------------------------------
    // apb and register next state
    // ------------------------------------------------------------
    logic wr_acc, new_evt;
    always_comb begin
        st_d = st_q;
        reload_d = reload_q;
        mask_d = mask_q;
        imask_d = imask_q;
        prdata_d = prdata_o;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        rd_rank_d = 1'b0;
        wr_acc = 1'b0;
        flag_d = flag_q | irq_req_i;
        new_evt = |(irq_req_i & ~flag_q);
        stat_d = stat_q;
        unique case (st_q)
            ifep_pkg::IFEP_APB_IDLE: begin
                if (psel_i && !penable_i) begin
                    st_d = ifep_pkg::IFEP_APB_ACCESS;
                end
            end
            ifep_pkg::IFEP_APB_ACCESS: begin
                if (psel_i && penable_i && !pready_o && !rd_rank_q) begin
                    wr_acc = pwrite_i;
                    if (is_rank && !pwrite_i) begin
                        rd_rank_d = 1'b1;
                    end else begin
                        pready_d = 1'b1;
                        st_d = ifep_pkg::IFEP_APB_IDLE;
                    end
                    prdata_d = 32'h0000_0000;
                    if (hit(paddr_i, `IFEP_OFS_RELOAD)) begin
                        prdata_d = reload_q;
                        if (wr_acc) reload_d = pwdata_i;
                    end else if (hit(paddr_i, `IFEP_OFS_FLAG)) begin
                        prdata_d = flag_q;
                        if (wr_acc) begin
                            // software set acts as an event; hw set wins
                            new_evt = new_evt | |(pwdata_i & ~flag_q);
                            flag_d = pwdata_i | irq_req_i;
                        end
                    end else if (hit(paddr_i, `IFEP_OFS_MASK)) begin
                        prdata_d = mask_q;
                        if (wr_acc) mask_d = pwdata_i;
                    end else if (hit(paddr_i, `IFEP_OFS_STAT)) begin
                        prdata_d = {30'h0000_0000, stat_q};
                        if (wr_acc) stat_d = stat_q & ~pwdata_i[1:0];
                    end else if (hit(paddr_i, `IFEP_OFS_IMASK)) begin
                        prdata_d = {30'h0000_0000, imask_q};
                        if (wr_acc) imask_d = pwdata_i[1:0];
                    end else if (hit(paddr_i, `IFEP_OFS_VEC)) begin
                        prdata_d = {21'h00_0000, vv_q, vl_q, vs_q, vn_q};
                    end else if (!is_rank) begin
                        pslverr_d = 1'b1;
                    end
                end else if (rd_rank_q) begin
                    prdata_d = rank_rd;
                    pready_d = 1'b1;
                    st_d = ifep_pkg::IFEP_APB_IDLE;
                end
            end
        endcase
        // events after the write so a set beats a clear
        pl_d = new_evt;
        if (new_evt) stat_d[`IFEP_STAT_EVENT] = 1'b1;
        if (new_evt) stat_d[`IFEP_STAT_TIMER] = 1'b1;
        irq_d = |(stat_d & imask_d);
    end

    // ------------------------------------------------------------
    // vector selection
    // ------------------------------------------------------------
    always_comb begin
        ifep_pkg::ifep_level_t l;
        ifep_pkg::ifep_sublevel_t s;
        l = 3'h0;
        s = 2'h0;
        vv_d = 1'b0;
        vn_d = 5'h00;
        vl_d = 3'h0;
        vs_d = 2'h0;
        for (int i = 0; i < NSRC && i < RANK_WORDS * 4; i++) begin
            l = lvl_of(rank_all, i);
            s = sub_of(rank_all, i);
            // masked or level zero sources go no further
            if (flag_q[i] && mask_q[i] && l != 3'h0) begin
                if (!vv_d || l > vl_d ||
                    (l == vl_d && s > vs_d)) begin
                    vv_d = 1'b1;
                    vn_d = 5'(i);
                    vl_d = l;
                    vs_d = s;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_q <= ifep_pkg::IFEP_APB_IDLE;
            reload_q <= `IFEP_RESET_WORD;
            flag_q <= `IFEP_RESET_WORD;
            mask_q <= `IFEP_RESET_WORD;
            stat_q <= 2'h0;
            imask_q <= 2'h0;
            prdata_o <= `IFEP_RESET_WORD;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            rd_rank_q <= 1'b0;
            vv_q <= 1'b0;
            vn_q <= 5'h00;
            vl_q <= 3'h0;
            vs_q <= 2'h0;
            pl_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            st_q <= st_d;
            reload_q <= reload_d;
            flag_q <= flag_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            imask_q <= imask_d;
            prdata_o <= prdata_d;
            pready_o <= pready_d;
            pslverr_o <= pslverr_d;
            rd_rank_q <= rd_rank_d;
            vv_q <= vv_d;
            vn_q <= vn_d;
            vl_q <= vl_d;
            vs_q <= vs_d;
            pl_q <= pl_d;
            irq_q <= irq_d;
        end
    end

    assign vec_valid_o = vv_q;
    assign vec_num_o = vn_q;
    assign vec_level_o = vl_q;
    assign vec_sublevel_o = vs_q;
    assign prox_load_o = pl_q;
    assign prox_value_o = reload_q;
    assign irq_o = irq_q;
endmodule
`default_nettype wire

// ### hw/ifep_defines.svh
// constants for the interrupt flag, enable and priority block
// assumes a 32-bit apb register map, byte addressed
// How it works
// - software-written 32-bit reload value loads proximity timer on each interrupt event.
// - flag bit reads 1 once its request occurred, 0 otherwise; 32 per register.
// - enable bit 1 allows its source, 0 disables it; matches flags one to one.
// - each slot has 3-bit priority, codes 001..111 mean levels 1..7.
// - priority code zero disables the vector; it is never presented.
// - each slot has 2-bit subpriority, codes 00..11 mean levels 0..3.
// - top slot priority at bits 28:26, subpriority at bits 25:24.
// - third slot priority at bits 20:18, subpriority at bits 17:16.
// - bits 31:29, 23:21, 15:13 (and 7:5) always read zero.
// - lower slots priority at 12:10 and 4:2, subpriority at 9:8 and 1:0.
// - every request input sampled on rising clock and latched into its flag.
// - a set flag with enable clear is masked from the vector; its event still loads the timer, sets status and can raise irq.
`ifndef IFEP_DEFINES_SVH
`define IFEP_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define IFEP_OFS_RELOAD 12'h000
`define IFEP_OFS_FLAG 12'h004
`define IFEP_OFS_MASK 12'h008
`define IFEP_OFS_STAT 12'h00c
`define IFEP_OFS_IMASK 12'h010
`define IFEP_OFS_VEC 12'h014
`define IFEP_OFS_RANK0 12'h020
`define IFEP_RANK_WORDS 8

// ------------------------------------------------------------
// rank word layout and reset values
// ------------------------------------------------------------
`define IFEP_RANK_IMPL 32'h1f1f_1f1f
`define IFEP_SLOT_STRIDE 8
`define IFEP_LVL_LSB 2
`define IFEP_RESET_WORD 32'h0000_0000
`define IFEP_STAT_EVENT 0
`define IFEP_STAT_TIMER 1

`endif

// ### hw/ifep_pkg.sv
// types for the interrupt flag, enable and priority block
// assumes nothing beyond the defines header
package ifep_pkg;
    typedef enum logic [1:0] {
        IFEP_APB_IDLE,
        IFEP_APB_ACCESS
    } ifep_apb_state_t;
    typedef logic [2:0] ifep_level_t;
    typedef logic [1:0] ifep_sublevel_t;
endpackage

// ### hw/ifep_rank_mem.sv
// small memory holding the vector rank words
// assumes the caller masks reserved bits on write
`timescale 1ns/1ps
`default_nettype none
`include "ifep_defines.svh"
module ifep_rank_mem #(
    parameter int WORDS = 8
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // write port
    input wire logic wr_en_i,
    input wire logic [$clog2(WORDS)-1:0] wr_idx_i,
    input wire logic [31:0] wr_data_i,
    // registered read port
    input wire logic [$clog2(WORDS)-1:0] rd_idx_i,
    output logic [31:0] rd_data_o,
    // flat view for the arbiter
    output logic [WORDS*32-1:0] all_o
);
    logic [31:0] mem_q [WORDS];
    logic [31:0] mem_d [WORDS];
    logic [31:0] rd_d;

    always_comb begin
        for (int i = 0; i < WORDS; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (wr_en_i) begin
            mem_d[wr_idx_i] = wr_data_i;
        end
        rd_d = mem_q[rd_idx_i];
    end

    always_ff @(posedge core_clk_i) begin
        for (int i = 0; i < WORDS; i++) begin
            mem_q[i] <= rst_n_i ? mem_d[i] : `IFEP_RESET_WORD;
        end
        rd_data_o <= rst_n_i ? rd_d : `IFEP_RESET_WORD;
    end

    always_comb begin
        for (int i = 0; i < WORDS; i++) begin
            all_o[i*32 +: 32] = mem_q[i];
        end
    end
endmodule
`default_nettype wire

// ### verif/ifep_req_model.sv
// peripheral side: raises one request line for one cycle on command
// assumes the bench drives fire_i and src_i just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ifep_req_model (
    // clock and command
    input wire logic core_clk_i,
    input wire logic fire_i,
    input wire logic [4:0] src_i,
    // request lines to the block
    output logic [31:0] irq_req_o
);
    initial irq_req_o = 32'h0000_0000;
    always @(posedge core_clk_i) begin
        irq_req_o <= fire_i ? (32'h0000_0001 << src_i) : 32'h0000_0000;
    end
endmodule
`default_nettype wire

// ### verif/ifep_checker.sv
// port assertions for the interrupt bookkeeping block
// assumes one clock domain and a bind onto ifep_top
`timescale 1ns/1ps
`default_nettype none
module ifep_checker #(
    parameter int NSRC = 32
) (
    // clock, reset and apb
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // vector and events
    input wire logic vec_valid_o,
    input wire logic [4:0] vec_num_o,
    input wire logic [2:0] vec_level_o,
    input wire logic [NSRC-1:0] irq_req_i,
    input wire logic prox_load_o,
    input wire logic irq_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_ready_pulse; pready_o |=> !pready_o; endproperty
    property p_ready_cause; pready_o |-> $past(psel_i && penable_i);
    endproperty
    property p_ready_bound;
        (psel_i && penable_i && !pready_o) |-> ##[1:2] pready_o;
    endproperty
    property p_err_ready; pslverr_o |-> pready_o; endproperty
    property p_rank_zero;
        (pready_o && !pwrite_i && paddr_i[11:5] == 7'h01)
            |-> (prdata_o & 32'he0e0_e0e0) == 32'h0000_0000;
    endproperty
    property p_level_nonzero; vec_valid_o |-> vec_level_o != 3'h0;
    endproperty
    property p_load_cause;
        prox_load_o |-> $past(irq_req_i) != {NSRC{1'b0}} ||
            ($past(psel_i) && $past(penable_i) && $past(pwrite_i));
    endproperty
    property p_reset_quiet;
        $rose(rst_n_i) |-> !vec_valid_o && !irq_o && !prox_load_o;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (p_ready_cause)
        else $error("pready without access phase");
    a_ready_bound: assert property (p_ready_bound)
        else $error("pready late");
    a_err_ready: assert property (p_err_ready)
        else $error("pslverr without pready");
    a_rank_zero: assert property (p_rank_zero)
        else $error("reserved rank bits read nonzero");
    a_level_nonzero: assert property (p_level_nonzero)
        else $error("vector presented at level zero");
    a_load_cause: assert property (p_load_cause)
        else $error("timer load without request or write");
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active after reset");
    c_err: cover property (pslverr_o);
    c_top: cover property (vec_valid_o && vec_level_o == 3'h7);
    c_irq: cover property ($rose(irq_o));
endmodule
bind ifep_top ifep_checker #(.NSRC(NSRC)) u_ifep_checker (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .vec_valid_o(vec_valid_o),
    .vec_num_o(vec_num_o),
    .vec_level_o(vec_level_o),
    .irq_req_i(irq_req_i),
    .prox_load_o(prox_load_o),
    .irq_o(irq_o)
);
`default_nettype wire

// ### verif/ifep_top_test.sv
// self-checking bench for the interrupt bookkeeping block
// assumes ifep_top, ifep_req_model and the defines header
`timescale 1ns/1ps
`default_nettype none
`include "ifep_defines.svh"
module ifep_top_test;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, irq_req, prox_value;
    logic pready, pslverr, vec_valid, prox_load, irq;
    logic [4:0] vec_num, src = 5'h00;
    logic [2:0] vec_level;
    logic [1:0] vec_sub;
    logic [31:0] vec;
    int n_errors = 0;
    int tests_run = 0;
    int n_load = 0;
    assign vec = {21'h0, vec_valid, vec_num, vec_level, vec_sub};
    always #4 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) if (prox_load === 1'b1) n_load++;
    ifep_top dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .irq_req_i(irq_req),
        .vec_valid_o(vec_valid), .vec_num_o(vec_num),
        .vec_level_o(vec_level), .vec_sublevel_o(vec_sub),
        .prox_load_o(prox_load), .prox_value_o(prox_value), .irq_o(irq));
    ifep_req_model u_req (.core_clk_i(core_clk_i), .fire_i(fire),
        .src_i(src), .irq_req_o(irq_req));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task finish_test;
        $display("mismatches %0d compares %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            n_errors++;
            finish_test();
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x, input logic ex);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, x);
        chk({31'h0, e}, {31'h0, ex});
    endtask
    task settle;
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask
    task pulse(input logic [4:0] s);
        @(posedge core_clk_i);
        fire <= 1'b1;
        src <= s;
        @(posedge core_clk_i);
        fire <= 1'b0;
        settle();
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int n0;
        repeat (8) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rd(`IFEP_OFS_RELOAD, 32'h0000_0000, 1'b0);
        rd(`IFEP_OFS_FLAG, 32'h0000_0000, 1'b0);
        rd(`IFEP_OFS_MASK, 32'h0000_0000, 1'b0);
        rd(`IFEP_OFS_RANK0, 32'h0000_0000, 1'b0);
        $display("test reset values done");
        wr(`IFEP_OFS_RELOAD, 32'hdead_beef);
        rd(`IFEP_OFS_RELOAD, 32'hdead_beef, 1'b0);
        chk(prox_value, 32'hdead_beef);
        wr(12'h024, 32'hffff_ffff);
        rd(12'h024, 32'h1f1f_1f1f, 1'b0);
        rd(12'hffc, 32'h0000_0000, 1'b1);
        $display("test register access done");
        wr(12'h024, 32'h0000_0d00);
        wr(`IFEP_OFS_STAT, 32'h0000_0003);
        wr(`IFEP_OFS_IMASK, 32'h0000_0001);
        n0 = n_load;
        pulse(5'h05);
        chk(n_load - n0, 32'h0000_0001);
        rd(`IFEP_OFS_FLAG, 32'h0000_0020, 1'b0);
        chk(vec, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(`IFEP_OFS_MASK, 32'h0000_0020);
        settle();
        chk(vec, {21'h0, 1'b1, 5'h05, 3'h3, 2'h1});
        wr(`IFEP_OFS_FLAG, 32'h0000_0000);
        wr(`IFEP_OFS_STAT, 32'h0000_0003);
        settle();
        chk(vec, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        $display("test flags and masking done");
        wr(`IFEP_OFS_FLAG, 32'h0000_0040);
        wr(`IFEP_OFS_MASK, 32'h0000_0040);
        settle();
        chk(vec, 32'h0000_0000);
        wr(12'h024, 32'h001d_0000);
        settle();
        chk(vec, {21'h0, 1'b1, 5'h06, 3'h7, 2'h1});
        wr(`IFEP_OFS_FLAG, 32'h0000_0010);
        wr(`IFEP_OFS_MASK, 32'h0000_0010);
        for (int k = 1; k < 8; k++) begin
            wr(12'h024, {27'h0, k[2:0], k[1:0]});
            settle();
            chk(vec, {21'h0, 1'b1, 5'h04, k[2:0], k[1:0]});
        end
        wr(`IFEP_OFS_FLAG, 32'h0000_0090);
        wr(`IFEP_OFS_MASK, 32'h0000_0090);
        wr(12'h024, 32'h0b00_0008);
        settle();
        chk(vec, {21'h0, 1'b1, 5'h07, 3'h2, 2'h3});
        wr(12'h024, 32'h0800_000b);
        settle();
        chk(vec, {21'h0, 1'b1, 5'h04, 3'h2, 2'h3});
        rd(`IFEP_OFS_VEC, 32'h0000_0564, 1'b0);
        $display("test priority and subpriority done");
        wr(`IFEP_OFS_STAT, 32'h0000_0003);
        wr(`IFEP_OFS_IMASK, 32'h0000_0000);
        pulse(5'h09);
        chk({31'h0, irq}, 32'h0000_0000);
        rd(`IFEP_OFS_FLAG, 32'h0000_0290, 1'b0);
        rd(`IFEP_OFS_STAT, 32'h0000_0003, 1'b0);
        wr(`IFEP_OFS_IMASK, 32'h0000_0001);
        settle();
        chk({31'h0, irq}, 32'h0000_0001);
        wr(`IFEP_OFS_STAT, 32'h0000_0001);
        settle();
        chk({31'h0, irq}, 32'h0000_0000);
        $display("test interrupt line done");
        finish_test();
    end
endmodule
`default_nettype wire
